// File: verilog/bttsa_defines.svh
`ifndef BTTSA_DEFINES_SVH
`define BTTSA_DEFINES_SVH

`define BTTSA_SUB_MODE2 8'hF7
`define BTTSA_SUB_MODE3 8'hFB
`define BTTSA_SUB_TRIGGER 8'hFD
`define BTTSA_BCR_ASYNC_BIT 7
`define BTTSA_MDB_TIMING_BIT 7
`define BTTSA_CNT_W 16
`define BTTSA_CNT_RESET 16'h0000
`define BTTSA_BUSMODE_W 3
`define BTTSA_BUSMODE_I2C 3'h0
`define BTTSA_BUSMODE_SDR 3'h1
`define BTTSA_BUSMODE_DDR 3'h2
`define BTTSA_BUSMODE_TSL 3'h3
`define BTTSA_BUSMODE_TSP 3'h4

`endif

// File: verilog/bttsa_pkg.sv
package bttsa_pkg;
  typedef enum logic [1:0] {
    BTTSA_MODE_OFF,
    BTTSA_MODE_LP,
    BTTSA_MODE_TRIG
  } bttsa_mode_t;

  typedef enum logic [2:0] {
    BTTSA_IDLE,
    BTTSA_WAIT_E1,
    BTTSA_WAIT_E2,
    BTTSA_WAIT_ACK,
    BTTSA_SEND
  } bttsa_state_t;
endpackage : bttsa_pkg

// File: verilog/bttsa_sync.sv
module bttsa_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic d_in,
  output logic q_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } bttsa_sync_t;

  bttsa_sync_t r;
  bttsa_sync_t next_r;

  always_comb begin
    next_r = r;
    if (ce_in) begin
      next_r.s1 = d_in;
      next_r.s2 = r.s1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q_out = r.s2;
endmodule : bttsa_sync

// File: verilog/bttsa_refclk.sv
`include "bttsa_defines.svh"

module bttsa_refclk (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [`BTTSA_BUSMODE_W-1:0] bus_mode_in,
  output logic fall_out
);
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic scl_d;
    logic sda_d;
    logic ref_lvl;
    logic ref_d;
  } bttsa_ref_t;

  bttsa_ref_t r;
  bttsa_ref_t next_r;

  function automatic logic is_ternary(input logic [`BTTSA_BUSMODE_W-1:0] m);
    is_ternary = (m == `BTTSA_BUSMODE_TSL) || (m == `BTTSA_BUSMODE_TSP);
  endfunction : is_ternary

  always_comb begin
    next_r = r;
    if (ce_in) begin
      // Pins pass two stages before any edge logic looks at them
      next_r.scl_s1 = scl_in;
      next_r.scl_s2 = r.scl_s1;
      next_r.sda_s1 = sda_in;
      next_r.sda_s2 = r.sda_s1;
      next_r.scl_d = r.scl_s2;
      next_r.sda_d = r.sda_s2;
      next_r.ref_d = r.ref_lvl;
      if (is_ternary(bus_mode_in)) begin
        // Any line change toggles the reference, so every transition is an edge
        if ((r.scl_s2 != r.scl_d) || (r.sda_s2 != r.sda_d)) begin // see (R04)
          next_r.ref_lvl = ~r.ref_lvl;
        end
      end else begin
        next_r.ref_lvl = r.scl_s2; // see (R03)
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      // Idle-high lines, so no false edge follows reset
      r <= '1;
    end else begin
      r <= next_r;
    end
  end

  assign fall_out = ce_in && r.ref_d && !r.ref_lvl;
endmodule : bttsa_refclk

// File: verilog/bttsa_top.sv
// Overview of operation
// (R01) Sub-command 0xF7 enters low-power timestamp mode
// (R02) Sub-command 0xFB enters triggerable timestamp mode
// (R03) Legacy, SDR, DDR: reference is clock line
// (R04) Ternary modes: every line transition makes edge
// (R05) Low-power event: oscillator on, both counters enabled
// (R06) Burst per oscillator cycle, ticks per falling
// (R07) Request interrupt at first bus-available condition
// (R08) Low-power: capture bursts on edges one, two
// (R09) Low-power ack: capture ticks, send burst, burst, ticks
// (R10) Controller runs and logs its own tick counter
// (R11) Controller computes event time from captures
// (R12) Characteristics byte bit 7 reads one
// (R13) Mandatory byte bit 7 flags timing data
// (R14) Controller starts sync with sub-command 0xFD
// (R15) Trigger transition bit edge zeroes, enables ticks
// (R16) Coarse delay zero: delay from fine only
// (R17) Controller keeps clock predictable during delay
// (R18) Triggerable event: oscillator on, burst counter enabled
// (R19) Triggerable first edge: capture ticks and burst
// (R20) Triggerable second edge: capture burst, halt ticks
// (R21) Triggerable ack: send burst, burst, ticks
// (R22) Controller runs tick counter after sync
// (R23) After sending, counters return to zero
`include "bttsa_defines.svh"

module bttsa_top (
  // Clocks, reset, enable
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  // Burst oscillator clock domain
  input wire logic BOSC_CLK_IN,
  // Bus lines
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic [`BTTSA_BUSMODE_W-1:0] BUS_MODE_IN,
  // Decoded timing command from the bus engine
  input wire logic SUBCMD_VALID_IN,
  input wire logic [7:0] SUBCMD_IN,
  input wire logic TRIG_TBIT_IN,
  // Trigger delay settings
  input wire logic [`BTTSA_CNT_W-1:0] COARSE_DELAY_IN,
  input wire logic [`BTTSA_CNT_W-1:0] FINE_DELAY_IN,
  // Sensor and interrupt handshake
  input wire logic EVENT_IN,
  input wire logic BUS_AVAIL_IN,
  input wire logic IBI_ACK_IN,
  input wire logic DATA_READY_IN,
  input wire logic CLEAR_BURST_IN,
  // Status and results
  output logic [1:0] MODE_OUT,
  output logic [7:0] BCR_OUT,
  output logic [7:0] MDB_OUT,
  output logic BOSC_EN_OUT,
  output logic IBI_REQ_OUT,
  output logic TRIGGER_OUT,
  output logic DATA_VALID_OUT,
  output logic [`BTTSA_CNT_W-1:0] DATA_OUT,
  output logic BUSY_OUT
);
  typedef struct packed {
    bttsa_pkg::bttsa_mode_t mode;
    bttsa_pkg::bttsa_state_t state;
    logic tick_run;
    logic [`BTTSA_CNT_W-1:0] tick_cnt;
    logic [`BTTSA_CNT_W-1:0] edge_tick_capture;
    logic [`BTTSA_CNT_W-1:0] first_burst_capture;
    logic [`BTTSA_CNT_W-1:0] second_burst_capture;
    logic osc_on;
    logic burst_clr;
    logic ibi_req;
    logic [1:0] send_idx;
    logic data_valid;
    logic [`BTTSA_CNT_W-1:0] data;
    logic dly_run;
    logic [`BTTSA_CNT_W-1:0] coarse_left;
    logic trigger;
    logic bclr_ack_d;
    logic fine_go_tgl;
  } bttsa_top_t;

  // Oscillator-domain state
  typedef struct packed {
    logic [`BTTSA_CNT_W-1:0] burst_cnt;
    logic [`BTTSA_CNT_W-1:0] burst_gray;
    logic clr_ack;
    logic [`BTTSA_CNT_W-1:0] fine_left;
    logic fine_run;
    logic fine_done_tgl;
  } bttsa_osc_t;

  bttsa_top_t r;
  bttsa_top_t next_r;
  bttsa_osc_t o;
  bttsa_osc_t next_o;

  logic ref_fall;
  logic event_s;
  logic event_d;
  logic ack_s;
  logic ack_d;
  logic avail_s;
  logic [`BTTSA_CNT_W-1:0] burst_gray_s1;
  logic [`BTTSA_CNT_W-1:0] burst_gray_s2;
  logic osc_en_s1;
  logic osc_en_s2;
  logic clr_req_s1;
  logic clr_req_s2;
  logic fine_go_s1;
  logic fine_go_s2;
  logic fine_go_d;
  logic clr_ack_s;
  logic fine_tgl_s;
  logic fine_tgl_d;
  logic [`BTTSA_CNT_W-1:0] burst_now;

  function automatic logic [`BTTSA_CNT_W-1:0] gray2bin(input logic [`BTTSA_CNT_W-1:0] g);
    logic [`BTTSA_CNT_W-1:0] b;
    b = g;
    for (int i = `BTTSA_CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction : gray2bin

  bttsa_refclk u_ref (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .bus_mode_in(BUS_MODE_IN),
    .fall_out(ref_fall)
  );

  bttsa_sync u_evt (
    .clk_in(CLK_IN), .rst_n_in(RST_N_IN), .ce_in(CE_IN), .d_in(EVENT_IN), .q_out(event_s)
  );
  bttsa_sync u_ack (
    .clk_in(CLK_IN), .rst_n_in(RST_N_IN), .ce_in(CE_IN), .d_in(IBI_ACK_IN), .q_out(ack_s)
  );
  bttsa_sync u_avl (
    .clk_in(CLK_IN), .rst_n_in(RST_N_IN), .ce_in(CE_IN), .d_in(BUS_AVAIL_IN), .q_out(avail_s)
  );
  bttsa_sync u_cak (
    .clk_in(CLK_IN), .rst_n_in(RST_N_IN), .ce_in(CE_IN), .d_in(o.clr_ack), .q_out(clr_ack_s)
  );
  bttsa_sync u_ftg (
    .clk_in(CLK_IN), .rst_n_in(RST_N_IN), .ce_in(CE_IN), .d_in(o.fine_done_tgl), .q_out(fine_tgl_s)
  );

  // Burst count crosses as gray code; two stages in the main domain
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      burst_gray_s1 <= `BTTSA_CNT_RESET;
      burst_gray_s2 <= `BTTSA_CNT_RESET;
      event_d <= 1'b0;
      ack_d <= 1'b0;
      fine_tgl_d <= 1'b0;
    end else if (CE_IN) begin
      burst_gray_s1 <= o.burst_gray;
      burst_gray_s2 <= burst_gray_s1;
      event_d <= event_s;
      ack_d <= ack_s;
      fine_tgl_d <= fine_tgl_s;
    end
  end

  assign burst_now = gray2bin(burst_gray_s2);

  always_comb begin
    next_r = r;
    next_r.data_valid = 1'b0;
    next_r.trigger = 1'b0;
    next_r.bclr_ack_d = clr_ack_s;
    if (CE_IN) begin
      if (SUBCMD_VALID_IN) begin
        if (SUBCMD_IN == `BTTSA_SUB_MODE2) begin
          next_r.mode = bttsa_pkg::BTTSA_MODE_LP; // see (R01)
        end else if (SUBCMD_IN == `BTTSA_SUB_MODE3) begin
          next_r.mode = bttsa_pkg::BTTSA_MODE_TRIG; // see (R02)
        end
      end
      // Edge counter advances on reference falling edges while enabled
      if (r.tick_run && ref_fall) begin
        next_r.tick_cnt = r.tick_cnt + 1'b1; // see (R06)
      end
      if (TRIG_TBIT_IN && r.mode == bttsa_pkg::BTTSA_MODE_TRIG) begin
        next_r.tick_cnt = `BTTSA_CNT_RESET; // see (R15)
        next_r.tick_run = 1'b1;
        next_r.dly_run = 1'b1;
        next_r.coarse_left = COARSE_DELAY_IN;
      end
      // Coarse part counted on reference edges, fine part by the oscillator
      if (r.dly_run) begin
        if (r.coarse_left == `BTTSA_CNT_RESET) begin
          next_r.dly_run = 1'b0; // see (R16)
          // Toggle, since a one-cycle pulse is shorter than an oscillator period
          next_r.fine_go_tgl = ~r.fine_go_tgl;
        end else if (ref_fall) begin
          next_r.coarse_left = r.coarse_left - 1'b1;
        end
      end
      if (fine_tgl_s != fine_tgl_d) begin
        next_r.trigger = 1'b1;
      end
      if (r.burst_clr && clr_ack_s && !r.bclr_ack_d) begin
        next_r.burst_clr = 1'b0;
      end
      case (r.state)
        bttsa_pkg::BTTSA_IDLE: begin
          if (event_s && !event_d && r.mode != bttsa_pkg::BTTSA_MODE_OFF && !r.burst_clr) begin
            next_r.osc_on = 1'b1; // see (R05) (R18)
            next_r.ibi_req = 1'b0;
            if (r.mode == bttsa_pkg::BTTSA_MODE_LP) begin
              next_r.tick_cnt = `BTTSA_CNT_RESET;
              next_r.tick_run = 1'b1; // see (R05)
            end
            next_r.state = bttsa_pkg::BTTSA_WAIT_E1;
          end
        end
        bttsa_pkg::BTTSA_WAIT_E1: begin
          if (ref_fall) begin
            next_r.first_burst_capture = burst_now; // see (R08) (R19)
            if (r.mode == bttsa_pkg::BTTSA_MODE_TRIG) begin
              next_r.edge_tick_capture = r.tick_cnt; // see (R19)
            end
            next_r.state = bttsa_pkg::BTTSA_WAIT_E2;
          end
        end
        bttsa_pkg::BTTSA_WAIT_E2: begin
          if (ref_fall) begin
            next_r.second_burst_capture = burst_now; // see (R08) (R20)
            next_r.osc_on = 1'b0;
            if (r.mode == bttsa_pkg::BTTSA_MODE_TRIG) begin
              next_r.tick_run = 1'b0; // see (R20)
            end
            if (CLEAR_BURST_IN) begin
              next_r.burst_clr = 1'b1;
            end
            next_r.state = bttsa_pkg::BTTSA_WAIT_ACK;
          end
        end
        bttsa_pkg::BTTSA_WAIT_ACK: begin
          if (ack_s && !ack_d) begin
            next_r.ibi_req = 1'b0;
            if (r.mode == bttsa_pkg::BTTSA_MODE_LP) begin
              next_r.edge_tick_capture = r.tick_cnt; // see (R09)
            end
            next_r.send_idx = 2'h0;
            next_r.state = bttsa_pkg::BTTSA_SEND;
          end
        end
        bttsa_pkg::BTTSA_SEND: begin
          if (DATA_READY_IN) begin
            next_r.data_valid = 1'b1;
            case (r.send_idx)
              2'h0: next_r.data = r.first_burst_capture; // see (R09) (R21)
              2'h1: next_r.data = r.second_burst_capture;
              default: next_r.data = r.edge_tick_capture;
            endcase
            next_r.send_idx = r.send_idx + 2'h1;
            if (r.send_idx == 2'h2) begin
              next_r.tick_run = 1'b0;
              next_r.tick_cnt = `BTTSA_CNT_RESET; // see (R23)
              next_r.burst_clr = 1'b1;
              next_r.state = bttsa_pkg::BTTSA_IDLE;
            end
          end
        end
        default: begin
          next_r.state = bttsa_pkg::BTTSA_IDLE;
        end
      endcase
      // Request held from the event until acknowledged, raised when bus is free
      if (r.state != bttsa_pkg::BTTSA_IDLE && r.state != bttsa_pkg::BTTSA_SEND && avail_s && !ack_s) begin
        next_r.ibi_req = 1'b1; // see (R07)
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Oscillator domain: enables arrive as levels over two flip-flops
  always_ff @(posedge BOSC_CLK_IN) begin
    if (!RST_N_IN) begin
      osc_en_s1 <= 1'b0;
      osc_en_s2 <= 1'b0;
      clr_req_s1 <= 1'b0;
      clr_req_s2 <= 1'b0;
      fine_go_s1 <= 1'b0;
      fine_go_s2 <= 1'b0;
      fine_go_d <= 1'b0;
    end else begin
      osc_en_s1 <= r.osc_on;
      osc_en_s2 <= osc_en_s1;
      clr_req_s1 <= r.burst_clr;
      clr_req_s2 <= clr_req_s1;
      fine_go_s1 <= r.fine_go_tgl;
      fine_go_s2 <= fine_go_s1;
      fine_go_d <= fine_go_s2;
    end
  end

  always_comb begin
    next_o = o;
    next_o.clr_ack = clr_req_s2;
    if (clr_req_s2) begin
      next_o.burst_cnt = `BTTSA_CNT_RESET; // see (R23)
    end else if (osc_en_s2) begin
      next_o.burst_cnt = o.burst_cnt + 1'b1; // see (R06)
    end
    next_o.burst_gray = next_o.burst_cnt ^ (next_o.burst_cnt >> 1);
    // Fine delay starts once the coarse part has ended
    if (fine_go_s2 != fine_go_d) begin
      next_o.fine_run = 1'b1;
      next_o.fine_left = FINE_DELAY_IN;
    end else if (o.fine_run) begin
      if (o.fine_left == `BTTSA_CNT_RESET) begin
        next_o.fine_run = 1'b0;
        next_o.fine_done_tgl = ~o.fine_done_tgl; // see (R16)
      end else begin
        next_o.fine_left = o.fine_left - 1'b1;
      end
    end
  end

  always_ff @(posedge BOSC_CLK_IN) begin
    if (!RST_N_IN) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  assign MODE_OUT = r.mode;
  assign BCR_OUT = 8'h80; // see (R12)
  assign MDB_OUT = 8'h80; // see (R13)
  assign BOSC_EN_OUT = r.osc_on;
  assign IBI_REQ_OUT = r.ibi_req;
  assign TRIGGER_OUT = r.trigger;
  assign DATA_VALID_OUT = r.data_valid;
  assign DATA_OUT = r.data;
  assign BUSY_OUT = (r.state != bttsa_pkg::BTTSA_IDLE) || r.burst_clr;
endmodule : bttsa_top

// File: test/bttsa_top_asserts.sv
`include "bttsa_defines.svh"

module bttsa_top_asserts (
  // Clock, reset, inputs
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic SUBCMD_VALID_IN,
  input wire logic [7:0] SUBCMD_IN,
  input wire logic IBI_ACK_IN,
  input wire logic DATA_READY_IN,
  // Outputs
  input wire logic [1:0] MODE_OUT,
  input wire logic [7:0] BCR_OUT,
  input wire logic [7:0] MDB_OUT,
  input wire logic BOSC_EN_OUT,
  input wire logic IBI_REQ_OUT,
  input wire logic TRIGGER_OUT,
  input wire logic DATA_VALID_OUT,
  input wire logic BUSY_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  a_bcr_async:
    assert property (BCR_OUT[7]) else $error("async capability bit low");
  a_mdb_timing:
    assert property (MDB_OUT[7]) else $error("timing flag bit low");
  a_enter_low:
    assert property (CE_IN && SUBCMD_VALID_IN && SUBCMD_IN == `BTTSA_SUB_MODE2 |-> ##[1:4] MODE_OUT == 2'h1)
    else $error("low-power mode not entered");
  a_enter_trig:
    assert property (CE_IN && SUBCMD_VALID_IN && SUBCMD_IN == `BTTSA_SUB_MODE3 |-> ##[1:4] MODE_OUT == 2'h2)
    else $error("triggerable mode not entered");
  a_osc_event:
    assert property ($rose(BOSC_EN_OUT) |-> BUSY_OUT && MODE_OUT != 2'h0) else $error("oscillator on while idle");
  a_ibi_hold:
    assert property (IBI_REQ_OUT && !IBI_ACK_IN && !$past(IBI_ACK_IN) && !$past(IBI_ACK_IN, 2)
      && !$past(IBI_ACK_IN, 3) |=> IBI_REQ_OUT) else $error("request dropped before ack");
  a_word_ready:
    assert property (DATA_VALID_OUT |-> $past(DATA_READY_IN) && !IBI_REQ_OUT && !BOSC_EN_OUT)
    else $error("word sent out of turn");
  a_trig_pulse:
    assert property (TRIGGER_OUT |=> !TRIGGER_OUT) else $error("trigger longer than one cycle");
  c_word: cover property (DATA_VALID_OUT);
  c_trig: cover property (TRIGGER_OUT);
  c_osc: cover property ($fell(BOSC_EN_OUT) && MODE_OUT == 2'h2);
endmodule : bttsa_top_asserts

bind bttsa_top bttsa_top_asserts chk_u (.CLK_IN, .RST_N_IN, .CE_IN, .SUBCMD_VALID_IN, .SUBCMD_IN,
  .IBI_ACK_IN, .DATA_READY_IN, .MODE_OUT, .BCR_OUT, .MDB_OUT, .BOSC_EN_OUT, .IBI_REQ_OUT,
  .TRIGGER_OUT, .DATA_VALID_OUT, .BUSY_OUT);

// File: test/bttsa_ctrl_model.sv
module bttsa_ctrl_model (
  // Clock and target request
  input wire logic clk_in,
  input wire logic ibi_req_in,
  // Bus and command lines
  output logic scl_out,
  output logic sda_out,
  output logic sub_valid_out,
  output logic [7:0] sub_out,
  output logic tbit_out,
  output logic ack_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int ticks;
  int ack_ticks;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    sub_valid_out = 1'b0;
    sub_out = 8'h00;
    tbit_out = 1'b0;
    ack_out = 1'b0;
    ticks = 0;
  end
  // Own tick counter counts clock falls, zeroed by the marked fall
  always @(negedge scl_out) ticks++;
  task automatic send_sub(input logic [7:0] code);
    @(negedge clk_in);
    sub_valid_out = 1'b1;
    sub_out = code;
    @(negedge clk_in);
    sub_valid_out = 1'b0;
    sub_out = ~code;
  endtask : send_sub
  // Fixed period keeps the reference predictable
  task automatic fall(input int gap, input bit mark);
    @(negedge clk_in);
    scl_out = 1'b0;
    if (mark) ticks = 0;
    repeat (4) @(negedge clk_in);
    tbit_out = mark;
    @(negedge clk_in);
    tbit_out = 1'b0;
    repeat (gap) @(negedge clk_in);
    scl_out = 1'b1;
    repeat (gap) @(negedge clk_in);
  endtask : fall
  task automatic flip(input int gap);
    @(negedge clk_in);
    sda_out = ~sda_out;
    repeat (gap + 2) @(negedge clk_in);
  endtask : flip
  task automatic ack(input int dly);
    repeat (dly) @(negedge clk_in);
    ack_out = 1'b1;
    ack_ticks = ticks;
    for (int k = 0; k < 50 && ibi_req_in; k++) @(negedge clk_in);
    ack_out = 1'b0;
  endtask : ack
endmodule : bttsa_ctrl_model

// File: test/testbench.sv
`include "bttsa_defines.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, bclk, rst_n, ev, avail, rdy, clr, scl, sda, sv, tb, ack, bosc, ibi, trig, dv, busy;
  logic [2:0] bm;
  logic [7:0] sub, bcr, mdb;
  logic [15:0] coarse, fine, dout;
  logic [15:0] w [3];
  logic [1:0] mode;
  logic [7:0] codes [3] = '{`BTTSA_SUB_MODE3, `BTTSA_SUB_TRIGGER, `BTTSA_SUB_MODE2};
  logic [1:0] modes [3] = '{2'h2, 2'h2, 2'h1};
  int n_errors, n_compared, seed, i, j, pre;
  time t_tb, t_tr;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    bclk = 1'b0;
    #7;
    forever #62.5 bclk = ~bclk;
  end
  bttsa_top dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1), .BOSC_CLK_IN(bclk), .SCL_IN(scl),
    .SDA_IN(sda), .BUS_MODE_IN(bm), .SUBCMD_VALID_IN(sv), .SUBCMD_IN(sub), .TRIG_TBIT_IN(tb),
    .COARSE_DELAY_IN(coarse), .FINE_DELAY_IN(fine), .EVENT_IN(ev), .BUS_AVAIL_IN(avail),
    .IBI_ACK_IN(ack), .DATA_READY_IN(rdy), .CLEAR_BURST_IN(clr), .MODE_OUT(mode), .BCR_OUT(bcr),
    .MDB_OUT(mdb), .BOSC_EN_OUT(bosc), .IBI_REQ_OUT(ibi), .TRIGGER_OUT(trig), .DATA_VALID_OUT(dv),
    .DATA_OUT(dout), .BUSY_OUT(busy));
  bttsa_ctrl_model ctrl_u (.clk_in(clk), .ibi_req_in(ibi), .scl_out(scl), .sda_out(sda),
    .sub_valid_out(sv), .sub_out(sub), .tbit_out(tb), .ack_out(ack));
  always @(posedge clk) begin
    if (tb === 1'b1) t_tb = $time;
    if (trig === 1'b1) t_tr = $time;
  end
  function automatic logic [15:0] exp_bursts(input int clks);
    return 16'(clks * 40 / 125);
  endfunction : exp_bursts
  function automatic logic [15:0] exp_ticks(input bit trigm, input int pre);
    return 16'(trigm ? pre : 3);
  endfunction : exp_ticks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic check_bit(input logic got, input logic exp);
    check(16'(got), 16'(exp));
  endtask : check_bit
  task automatic check_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_errors++;
      $display("BAD %0t got %h outside %h to %h", $time, got, lo, hi);
    end
  endtask : check_rng
  task automatic wait_on(ref logic s, input logic v);
    for (int k = 0; k < 300 && s !== v; k++) @(negedge clk);
  endtask : wait_on
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic run_event(input bit trigm, input bit tern, input int pre);
    int n;
    bm = tern ? 3'(3 + $unsigned($random(seed)) % 2) : 3'($unsigned($random(seed)) % 3);
    clr = $random(seed);
    ev = 1'b1;
    wait_on(bosc, 1'b1);
    check_bit(bosc, 1'b1);
    avail = 1'b1;
    wait_on(ibi, 1'b1);
    check_bit(ibi, 1'b1);
    // Third reference fall must not reach the burst captures
    for (j = 0; j < 3; j++) begin
      if (tern) begin
        ctrl_u.flip(20);
        ctrl_u.flip(20);
      end else begin
        ctrl_u.fall(20, 1'b0);
      end
    end
    check_bit(bosc, 1'b0);
    if (!tern) ctrl_u.flip(2);
    ev = 1'b0;
    ctrl_u.ack($unsigned($random(seed)) % 30);
    n = 0;
    for (j = 0; j < 200 && n < 3; j++) begin
      @(negedge clk);
      if (dv === 1'b1) begin
        w[n] = dout;
        n++;
      end
      rdy = $random(seed);
    end
    rdy = 1'b0;
    avail = 1'b0;
    check(16'(n), 16'h0003);
    check_rng(w[1] - w[0], exp_bursts(46) - 16'h0001, exp_bursts(46) + 16'h0003);
    check(w[2], exp_ticks(trigm, pre));
    wait_on(busy, 1'b0);
    check_bit(busy, 1'b0);
    $display("event test done, triggerable %0d", trigm);
  endtask : run_event
  initial begin
    seed = 32'h9BAD;
    {rst_n, ev, avail, rdy, clr, bm, coarse, fine, n_errors, n_compared, t_tb, t_tr} = '0;
    repeat (3) @(negedge clk);
    // Oscillator domain needs its own edges in reset
    repeat (2) @(posedge bclk);
    @(negedge clk);
    rst_n = 1'b1;
    check(16'(bcr), 16'h0080);
    check(16'(mdb), 16'h0080);
    ev = 1'b1;
    repeat (12) @(negedge clk);
    check_bit(bosc, 1'b0);
    ev = 1'b0;
    for (i = 0; i < 3; i++) begin
      ctrl_u.send_sub(codes[i]);
      repeat (6) @(negedge clk);
      check(16'(mode), 16'(modes[i]));
    end
    $display("mode test done");
    for (i = 0; i < 3; i++) run_event(1'b0, i == 2, 0);
    ctrl_u.send_sub(`BTTSA_SUB_MODE3);
    for (i = 0; i < 2; i++) begin
      pre = 1 + $unsigned($random(seed)) % 3;
      fine = 16'(2 + $unsigned($random(seed)) % 8);
      bm = 3'h0;
      ctrl_u.send_sub(`BTTSA_SUB_TRIGGER);
      ctrl_u.fall(20, 1'b1);
      for (j = 0; j < pre - 1; j++) ctrl_u.fall(20, 1'b0);
      // Trigger may come after the last fall when the fine delay is long
      for (j = 0; j < 300 && t_tr <= t_tb; j++) @(negedge clk);
      check_rng(16'((t_tr - t_tb) / 40), fine * 3 + 16'h0008, fine * 4 + 16'h0014);
      run_event(1'b1, 1'b0, pre - 1);
    end
    final_report();
  end
  initial begin
    #400000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end
endmodule : testbench
